/* File: core/pes_pkg.sv */
// package of constants and carrier types for the parity error signalling block
// assumes a 100 MHz core clock and a classic wishbone register bus
package pes_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] PES_CTRL_OFS   = 4'h0;
   localparam logic [3:0] PES_STATUS_OFS = 4'h4;
   localparam logic [3:0] PES_CFG_OFS    = 4'h8;
   // ---------------------------------------------------------------
   // control byte fields
   // ---------------------------------------------------------------
   localparam int PES_CTL_IRQ_EN   = 0;
   localparam int PES_CTL_URG_EN   = 1;
   localparam int PES_CTL_IND_EN   = 2;
   localparam int PES_CTL_EVEN     = 3;
   localparam logic [3:0] PES_CTL_RST = 4'h0;
   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   localparam int PES_CFG_ADDR0    = 0;
   localparam int PES_CFG_PF_EN    = 1;
   localparam int PES_CFG_GATE_INV = 2;
   localparam logic [2:0] PES_CFG_RST = 3'h0;
   // ---------------------------------------------------------------
   // status fields
   // ---------------------------------------------------------------
   localparam int PES_ST_LOW   = 0;
   localparam int PES_ST_HIGH  = 1;
   localparam int PES_ST_IRQ   = 2;
   localparam int PES_ST_URG   = 3;
   // ---------------------------------------------------------------
   // memory side
   // ---------------------------------------------------------------
   localparam logic [15:0] PES_CTL_ADDR_DEF = 16'h0400;
   localparam logic [15:0] PES_CTL_ADDR_ALT = 16'h0000;
   localparam int PES_MEM_AW = 8;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int PES_CLK_MHZ      = 100;
   localparam int PES_PWRUP_MS     = 10;
   localparam int PES_PWRUP_CYC    = PES_PWRUP_MS * 1000 * PES_CLK_MHZ;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        strobe_n;
      logic [15:0] addr;
      logic [15:0] data;
   } pes_mem_s;
   typedef struct packed {
      logic high;
      logic low;
   } pes_lane_s;
endpackage

/* File: core/pes_top.sv */
// parity error signalling: parity store, checker, error latches and interrupts
// assumes memory strobes and pins come asynchronously; registers over classic wishbone
// Function
// [RL1] maskable irq output asserts on parity error
// [RL2] urgent irq output asserts on error condition
// [RL3] latched low lane error status output
// [RL4] latched high lane error status output
// [RL5] gate input enables the urgent irq
// [RL6] power fail ORed into urgent irq
// [RL7] power fail use option, default off
// [RL8] option inverts sense of gate input
// [RL9] write strobe rise clears irq and status
// [RL10] write strobe rise clears urgent irq
// [RL11] gate going high clears urgent irq
// [RL12] read strobe rise updates maskable irq
// [RL13] read strobe rise updates urgent irq
// [RL14] read strobe rise updates lane statuses
// [RL15] host waits 10 ms after power-up
// [RL16] control port at 400H, or 0H option
// [RL17] reset clears control byte, masks all
// [RL18] maskable latch holds until command or reset
// [RL19] urgent latch holds until command, reset, gate
// [RL20] parity stored per lane, checked on read
`timescale 1ns/1ps
module pes_top #(
   parameter int PWRUP_CYC = pes_pkg::PES_PWRUP_CYC,
   parameter int MEM_AW    = pes_pkg::PES_MEM_AW
) (
   input  wire  logic        core_clk,
   input  wire  logic        nrst,
   input  wire  logic        wb_cyc_i,
   input  wire  logic        wb_stb_i,
   input  wire  logic        wb_we_i,
   input  wire  logic [3:0]  wb_adr_i,
   input  wire  logic [3:0]  wb_sel_i,
   input  wire  logic [31:0] wb_dat_i,
   output logic        [31:0] wb_dat_o,
   output logic               wb_ack_o,
   input  wire  logic        low_write_strobe_n,
   input  wire  logic        dual_port_read_strobe_n,
   input  wire  logic [15:0] mem_addr,
   input  wire  logic [15:0] mem_data,
   input  wire  logic        urgent_irq_gate,
   input  wire  logic        power_fail_in,
   output logic               parity_irq,
   output logic               urgent_irq,
   output logic               low_lane_error,
   output logic               high_lane_error,
   output logic               access_ready
);
   // ---------------------------------------------------------------
   // pin synchronisers: three flops, change taken when 2nd and 3rd agree
   // ---------------------------------------------------------------
   localparam int NP = 4;
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] s1;
   logic [NP-1:0] s2;
   logic [NP-1:0] s3;
   logic [NP-1:0] pin_q;
   logic [NP-1:0] pin_d;
   assign pin_raw = {power_fail_in, urgent_irq_gate, dual_port_read_strobe_n, low_write_strobe_n};

   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_sync
         // idle level of strobes is high, of gate and power fail low
         localparam logic IDLE = (gi < 2) ? 1'b1 : 1'b0;
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               s1[gi]    <= IDLE;
               s2[gi]    <= IDLE;
               s3[gi]    <= IDLE;
               pin_q[gi] <= IDLE;
               pin_d[gi] <= IDLE;
            end else begin
               s1[gi]    <= pin_raw[gi];
               s2[gi]    <= s1[gi];
               s3[gi]    <= s2[gi];
               pin_d[gi] <= pin_q[gi];
               if (s2[gi] == s3[gi]) begin
                  pin_q[gi] <= s3[gi];
               end
            end
         end
      end
   endgenerate

   wire wr_rise = pin_q[0] & ~pin_d[0];
   wire rd_rise = pin_q[1] & ~pin_d[1];
   wire wr_fall = ~pin_q[0] & pin_d[0];
   wire rd_fall = ~pin_q[1] & pin_d[1];
   wire gate_lv = pin_q[2];
   wire pf_lv   = pin_q[3];

   // ---------------------------------------------------------------
   // address and data captured while strobes are low
   // ---------------------------------------------------------------
   pes_pkg::pes_mem_s cap;
   wire cap_now = wr_fall | rd_fall;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [3:0] ctrl;
   logic [2:0] cfg;
   logic       irq_lat;
   logic       urg_lat;
   pes_pkg::pes_lane_s lane;
   logic [(1<<MEM_AW)-1:0] par_lo;
   logic [(1<<MEM_AW)-1:0] par_hi;
   logic [31:0] pwr_cnt;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire sel_ctrl = wb_adr_i == pes_pkg::PES_CTRL_OFS;
   wire sel_st   = wb_adr_i == pes_pkg::PES_STATUS_OFS;
   wire sel_cfg  = wb_adr_i == pes_pkg::PES_CFG_OFS;
   wire wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
   wire [15:0] ctl_addr = cfg[pes_pkg::PES_CFG_ADDR0] ? pes_pkg::PES_CTL_ADDR_ALT
                                                     : pes_pkg::PES_CTL_ADDR_DEF; // see [RL16]
   wire ctl_hit  = cap.addr == ctl_addr;
   wire ctl_wr   = wr_rise & ctl_hit;                                           // see [RL16]
   wire [MEM_AW-1:0] idx = cap.addr[MEM_AW-1:0];
   wire even     = ctrl[pes_pkg::PES_CTL_EVEN];
   // parity bit kept so byte plus bit has odd (or even) ones
   wire gen_lo   = ~(^cap.data[7:0]) ^ even;                                    // see [RL20]
   wire gen_hi   = ~(^cap.data[15:8]) ^ even;                                   // see [RL20]
   wire chk_lo   = gen_lo ^ par_lo[idx];                                        // see [RL20]
   wire chk_hi   = gen_hi ^ par_hi[idx];                                        // see [RL20]
   wire rd_err   = chk_lo | chk_hi;
   wire gate_on  = gate_lv ^ cfg[pes_pkg::PES_CFG_GATE_INV];                    // see [RL8]
   wire gate_d   = pin_d[2] ^ cfg[pes_pkg::PES_CFG_GATE_INV];
   wire gate_up  = gate_on & ~gate_d;
   wire pf_hit   = pf_lv & cfg[pes_pkg::PES_CFG_PF_EN];                         // see [RL6] [RL7]
   wire urg_set  = (rd_rise & rd_err & ctrl[pes_pkg::PES_CTL_URG_EN]) | pf_hit; // see [RL13] [RL6]
   wire irq_set  = rd_rise & rd_err & ctrl[pes_pkg::PES_CTL_IRQ_EN];            // see [RL12]
   wire [3:0] st_word = {urg_lat, irq_lat, lane.high, lane.low};
   wire [31:0] rd_mux = sel_ctrl ? {28'h0, ctrl} :
                        sel_st   ? {28'h0, st_word} :
                        sel_cfg  ? {29'h0, cfg} : 32'h0;

   // ---------------------------------------------------------------
   // capture and parity store
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cap <= '0;
      end else if (cap_now) begin
         cap <= '{strobe_n: 1'b0, addr: mem_addr, data: mem_data};
      end
   end

   // parity bits written at the end of the write, after capture settled
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         par_lo <= '0;
      end else if (wr_rise) begin
         par_lo[idx] <= gen_lo;                                                 // see [RL20]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         par_hi <= '0;
      end else if (wr_rise) begin
         par_hi[idx] <= gen_hi;                                                 // see [RL20]
      end
   end

   // ---------------------------------------------------------------
   // control byte and configuration
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= pes_pkg::PES_CTL_RST;                                          // see [RL17]
         cfg  <= pes_pkg::PES_CFG_RST;                                          // see [RL7] [RL16]
      end else begin
         if (ctl_wr) begin
            ctrl <= cap.data[3:0];
         end else if (wb_wr & sel_ctrl) begin
            ctrl <= wb_dat_i[3:0];
         end
         if (wb_wr & sel_cfg) begin
            cfg <= wb_dat_i[2:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // error latches; a set in the clearing cycle wins
   // ---------------------------------------------------------------
   wire urg_clr      = ctl_wr | gate_up;                                        // see [RL10] [RL11]
   wire lane_upd     = rd_rise & ctrl[pes_pkg::PES_CTL_IND_EN];                 // see [RL14]
   wire next_irq_lat = irq_set | (irq_lat & ~ctl_wr);                           // see [RL1] [RL9] [RL18]
   wire next_urg_lat = urg_set | (urg_lat & ~urg_clr);                          // see [RL2] [RL10] [RL19]
   wire next_lane_lo = lane_upd ? chk_lo : (lane.low & ~ctl_wr);                // see [RL3] [RL9]
   wire next_lane_hi = lane_upd ? chk_hi : (lane.high & ~ctl_wr);               // see [RL4] [RL9]

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_lat <= 1'b0;                                                       // see [RL17]
      end else begin
         irq_lat <= next_irq_lat;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         urg_lat <= 1'b0;                                                       // see [RL17]
      end else begin
         urg_lat <= next_urg_lat;
      end
   end

   // lane results kept even when the indicators are masked off later
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lane <= '0;                                                            // see [RL17]
      end else begin
         lane <= '{high: next_lane_hi, low: next_lane_lo};
      end
   end

   // ---------------------------------------------------------------
   // outputs, each from its own flop
   // ---------------------------------------------------------------
   // the gate hides the urgent latch while off; the latch keeps its state until the gate turns on, which clears it
   wire next_urgent_irq = urg_lat & gate_on;                                    // see [RL5] [RL2]

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         parity_irq <= 1'b0;
      end else begin
         parity_irq <= irq_lat;                                                 // see [RL1]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         urgent_irq <= 1'b0;
      end else begin
         urgent_irq <= next_urgent_irq;                                         // see [RL2]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         low_lane_error <= 1'b0;
      end else begin
         low_lane_error <= lane.low;                                            // see [RL3]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         high_lane_error <= 1'b0;
      end else begin
         high_lane_error <= lane.high;                                          // see [RL4]
      end
   end

   // ---------------------------------------------------------------
   // power-up wait
   // ---------------------------------------------------------------
   // counter saturates so ready never falls back during a long run
   wire pwr_done = pwr_cnt >= 32'(PWRUP_CYC);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pwr_cnt <= 32'h0;
      end else if (!pwr_done) begin
         pwr_cnt <= pwr_cnt + 32'h1;                                            // see [RL15]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         access_ready <= 1'b0;
      end else begin
         access_ready <= pwr_done;                                              // see [RL15]
      end
   end

   // ---------------------------------------------------------------
   // bus answer: one-cycle ack, data only beside it
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wb_dat_o <= 32'h0;
      end else begin
         wb_dat_o <= wb_req ? rd_mux : 32'h0;
      end
   end
endmodule // pes_top

/* File: tb/pes_top_assertions.sv */
// checker of the error signalling outputs of pes_top
// assumes one core_clk domain; strobe, gate and power fail pins are asynchronous
`timescale 1ns/1ps
module pes_top_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic low_write_strobe_n,
   input wire logic dual_port_read_strobe_n,
   input wire logic urgent_irq_gate,
   input wire logic power_fail_in,
   input wire logic parity_irq,
   input wire logic urgent_irq,
   input wire logic low_lane_error,
   input wire logic high_lane_error,
   input wire logic access_ready
);
   // ---------------------------------------------------------------
   // cycles since each cause, saturating at 15
   // ---------------------------------------------------------------
   logic [3:0] n_rd, n_wr, n_gt, n_pf, next_n_rd, next_n_wr, next_n_gt, next_n_pf;
   logic       rd_q, wr_q, gt_q;
   function automatic logic [3:0] sat(input logic [3:0] v);
      return (v == 4'hf) ? v : v + 4'h1;
   endfunction
   assign next_n_rd = (dual_port_read_strobe_n & ~rd_q) ? 4'h0 : sat(n_rd);
   assign next_n_wr = (low_write_strobe_n & ~wr_q) ? 4'h0 : sat(n_wr);
   assign next_n_gt = (urgent_irq_gate != gt_q) ? 4'h0 : sat(n_gt);
   assign next_n_pf = power_fail_in ? 4'h0 : sat(n_pf);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         {rd_q, wr_q, gt_q} <= 3'h6;
         {n_rd, n_wr, n_gt, n_pf} <= 16'hffff;
      end else begin
         {rd_q, wr_q, gt_q} <= {dual_port_read_strobe_n, low_write_strobe_n, urgent_irq_gate};
         {n_rd, n_wr, n_gt, n_pf} <= {next_n_rd, next_n_wr, next_n_gt, next_n_pf};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over one cycle");
   chk_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   chk_irq_from_read: assert property ($rose(parity_irq) |-> n_rd <= 4'ha)
      else $error("maskable irq set without a read");
   chk_irq_held_set: assert property ($fell(parity_irq) |-> n_wr <= 4'ha)
      else $error("maskable irq dropped without a command");
   chk_urg_from_cause: assert property ($rose(urgent_irq) |-> n_rd <= 4'ha || n_pf <= 4'ha || n_gt <= 4'ha)
      else $error("urgent irq set without cause");
   chk_urg_held_set: assert property ($fell(urgent_irq) |-> n_wr <= 4'ha || n_gt <= 4'ha)
      else $error("urgent irq dropped without cause");
   chk_low_from_read: assert property ($rose(low_lane_error) |-> n_rd <= 4'ha)
      else $error("low lane error set without a read");
   chk_high_from_read: assert property ($rose(high_lane_error) |-> n_rd <= 4'ha)
      else $error("high lane error set without a read");
   chk_lane_clear_src: assert property ($fell(low_lane_error) || $fell(high_lane_error) |-> ##[0:1] n_wr <= 4'hb || n_rd <= 4'hb)
      else $error("lane error dropped without cause");
   chk_ready_stays: assert property (access_ready |=> access_ready)
      else $error("access ready dropped");
   cover property ($rose(parity_irq));
   cover property ($fell(urgent_irq) && n_gt <= 4'ha);
   cover property ($rose(urgent_irq) && n_pf <= 4'ha);
endmodule // pes_top_chk
bind pes_top pes_top_chk i_pes_top_chk (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .low_write_strobe_n(low_write_strobe_n), .dual_port_read_strobe_n(dual_port_read_strobe_n),
   .urgent_irq_gate(urgent_irq_gate), .power_fail_in(power_fail_in), .parity_irq(parity_irq),
   .urgent_irq(urgent_irq), .low_lane_error(low_lane_error), .high_lane_error(high_lane_error),
   .access_ready(access_ready));

/* File: tb/pes_host.sv */
// base board memory model that drives the parity board strobes
// assumes each access starts right after a rising core_clk edge
`timescale 1ns/1ps
module pes_host (
   input  wire logic        core_clk,
   output logic             low_write_strobe_n,
   output logic             dual_port_read_strobe_n,
   output logic [15:0]      mem_addr,
   output logic [15:0]      mem_data
);
   logic [15:0] ram [256];
   initial begin
      {low_write_strobe_n, dual_port_read_strobe_n} = 2'h3;
      {mem_addr, mem_data} = 32'h5a5aa5a5;
      foreach (ram[i]) ram[i] = 16'h0;
   end
   task automatic acc(input logic wr, input logic [15:0] a, d);
      logic [15:0] v;
      v = wr ? d : ram[a[7:0]];
      if (wr) ram[a[7:0]] = d;
      mem_addr <= a;
      mem_data <= v;
      @(posedge core_clk);
      low_write_strobe_n <= ~wr;
      dual_port_read_strobe_n <= wr;
      repeat (6) @(posedge core_clk);
      {low_write_strobe_n, dual_port_read_strobe_n} <= 2'h3;
      repeat (4) @(posedge core_clk);
      mem_addr <= ~a;   // released bus shows no stale value
      mem_data <= ~v;
      repeat (8) @(posedge core_clk);
   endtask
endmodule // pes_host

/* File: tb/parity_error_signalling_test.sv */
// self-checking bench of pes_top with a base board model
// assumes pes_host and the bound checker are compiled alongside
`timescale 1ns/1ps
module parity_error_signalling_test;
   logic        core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, access_ready, power_fail_in;
   logic        low_write_strobe_n, dual_port_read_strobe_n, urgent_irq_gate;
   logic        parity_irq, urgent_irq, low_lane_error, high_lane_error;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [15:0] mem_addr, mem_data;
   int          err_total, n_compared, n;
   pes_top #(.PWRUP_CYC(20), .MEM_AW(8)) i_pes_top (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_write_strobe_n(low_write_strobe_n),
      .dual_port_read_strobe_n(dual_port_read_strobe_n), .mem_addr(mem_addr), .mem_data(mem_data),
      .urgent_irq_gate(urgent_irq_gate), .power_fail_in(power_fail_in), .parity_irq(parity_irq),
      .urgent_irq(urgent_irq), .low_lane_error(low_lane_error), .high_lane_error(high_lane_error),
      .access_ready(access_ready));
   pes_host i_pes_host (.core_clk(core_clk), .low_write_strobe_n(low_write_strobe_n),
      .dual_port_read_strobe_n(dual_port_read_strobe_n), .mem_addr(mem_addr), .mem_data(mem_data));
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // order: urgent, maskable, high lane, low lane
   task automatic outs(input logic [3:0] e);
      chk("outputs", {28'h0, e}, {28'h0, urgent_irq, parity_irq, high_lane_error, low_lane_error});
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'h1, d};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 50);
      if (n >= 50) begin
         err_total++;
         results();
      end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(1'h0, a, 32'h0);
      chk("register", e, q);
   endtask
   task automatic pins(input logic g, p, input logic [3:0] e);
      {urgent_irq_gate, power_fail_in} <= {g, p};
      repeat (12) @(posedge core_clk);
      outs(e);
   endtask
   initial begin
      {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
      {urgent_irq_gate, power_fail_in, err_total, n_compared} = {2'h2, 64'h0};
      repeat (6) @(posedge core_clk);
      nrst <= 1'h1;
      @(posedge core_clk);
      outs(4'h0);
      rd(pes_pkg::PES_CTRL_OFS, 32'h0);
      rd(pes_pkg::PES_CFG_OFS, 32'h0);
      rd(4'hc, 32'h0);
      for (n = 0; n < 100 && access_ready !== 1'h1; n++) @(posedge core_clk);
      chk("access ready", 32'h1, {31'h0, access_ready});
      $display("test reset done");
      i_pes_host.acc(1'h1, 16'h0010, 16'h1234);
      i_pes_host.acc(1'h1, 16'h0400, 16'h000f);
      rd(pes_pkg::PES_CTRL_OFS, 32'hf);
      i_pes_host.acc(1'h0, 16'h0010, 16'h0);
      outs(4'hf);
      pins(1'h1, 1'h0, 4'hf);
      pins(1'h0, 1'h0, 4'h7);
      pins(1'h1, 1'h0, 4'h7);
      rd(pes_pkg::PES_STATUS_OFS, 32'h7);
      $display("test error latch done");
      i_pes_host.acc(1'h0, 16'h0010, 16'h0);
      outs(4'hf);
      i_pes_host.acc(1'h1, 16'h0400, 16'h000f);
      outs(4'h0);
      wb(1'h1, pes_pkg::PES_CFG_OFS, 32'h4);
      i_pes_host.acc(1'h0, 16'h0010, 16'h0);
      outs(4'h7);
      rd(pes_pkg::PES_STATUS_OFS, 32'hf);
      pins(1'h0, 1'h0, 4'h7);
      rd(pes_pkg::PES_STATUS_OFS, 32'h7);
      $display("test gate done");
      i_pes_host.acc(1'h1, 16'h0400, 16'h000f);
      wb(1'h1, pes_pkg::PES_CFG_OFS, 32'h0);
      pins(1'h1, 1'h1, 4'h0);
      wb(1'h1, pes_pkg::PES_CFG_OFS, 32'h2);
      pins(1'h1, 1'h1, 4'h8);
      pins(1'h1, 1'h0, 4'h8);
      $display("test power fail done");
      wb(1'h1, pes_pkg::PES_CFG_OFS, 32'h3);
      i_pes_host.acc(1'h0, 16'h0010, 16'h0);
      i_pes_host.acc(1'h1, 16'h0400, 16'h000f);
      outs(4'hf);
      i_pes_host.acc(1'h1, 16'h0000, 16'h0000);
      outs(4'h0);
      $display("test address option done");
      results();
   end
endmodule // parity_error_signalling_test
